// ---- rtl/rirc_ctrl.v ----
// Reset latch, clock-stop wake and interrupt return control
//
// Operation
// [R1] reti bit 2 restores pre-interrupt speed
// [R2] reti bit 1 writes next address to vector
// [R3] reti bit 0 adds accumulator to timer0
// [R4] Next interrupt starts after updating reti
// [R5] reti then two refill cycles at mainline speed
// [R6] Disabled peripheral cannot set its flag
// [R7] Software-set enabled flag still interrupts
// [R8] Software clears flag of peripheral it disables
// [R9] Speed stops core clock or system clock
// [R10] Interrupt logic runs while clocks stopped
// [R11] Port and timer interrupts wake without reset
// [R12] Watchdog, brown-out, pin wake via reset
// [R13] Every reset loads PC with FFF0
// [R14] Startup timer runs after pin high, clears latch
// [R15] Wakeup delay fuse sets startup length
// [R16] Watchdog cause bit tracks reset source
// [R17] Brown-out cause bit tracks reset source
// [R18] Held in reset while supply below threshold
// [R19] Level fuse selects threshold, 111 disables
// [R20] Fuses not writable by the program
// [R21] Single vector, default zero, two update paths
// [R22] Software sets vector before enabling interrupts
// [R23] reti sets global interrupt enable
// [R24] reti restores PC from saved PC
// [R25] Entry shadows speed, loads interrupt speed
// [R26] Any source sets latch, restarts timer
// [R27] All three reti options act together
`timescale 1ns/1ps
`include "rirc_defs.vh"
module rirc_ctrl (
    input wire clk_sys, // System clock, 40 MHz
    input wire rst_n, // Power-on reset, active low
    input wire [7:0] paddr, // APB address
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB write
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error on unmapped address
    input wire rst_pin_n, // External reset pin, active low
    input wire bod_low, // Brown-out comparator: supply below level
    input wire wdt_ovf, // Watchdog overflow
    input wire dbg_rst, // Debug target reset
    input wire port_evt, // Port interrupt edge event
    input wire rtc_evt, // Real-time timer event
    input wire [7:0] fuse_a_in, // Fuse cells, wakeup delay in [2:0]
    input wire [7:0] fuse_b_in, // Fuse cells, brown-out level in [2:0]
    input wire core_tick, // Core clock enable from the divider
    input wire [15:0] core_pc, // PC to save on interrupt entry
    input wire reti_vld, // Return instruction executes
    input wire [2:0] reti_opt, // Return option bits
    input wire [15:0] reti_pc, // Address of the return instruction
    input wire [7:0] w_acc, // Working accumulator
    output reg cpu_rst, // Core held in reset
    output reg pc_load, // Load PC pulse
    output reg [15:0] pc_val, // PC value to load
    output reg irq_take, // Interrupt entry pulse
    output reg core_stall, // Pipeline refill hold
    output reg core_clk_en, // Core clock gate
    output reg sys_clk_en, // System clock gate
    output reg wdt_run, // Watchdog keeps running in stop
    output reg rtc_run, // Real-time timer keeps running in stop
    output reg bod_en, // Brown-out detector enabled
    output reg [2:0] bod_level // Brown-out threshold select
);

// ------------------------------------------------------------
// Declarations
// ------------------------------------------------------------
wire [5:0] pin_q;
wire pin_high = pin_q[0];
wire bod_q = pin_q[1];
wire wdt_q = pin_q[2];
wire dbg_q = pin_q[3];
wire port_q = pin_q[4];
wire rtc_q = pin_q[5];

reg port_d_r;
reg rtc_d_r;
reg rst_latch_r;
reg [9:0] start_cnt_r;
reg wd_cause_r;
reg bo_cause_r;
reg [7:0] fuse_config_a;
reg [7:0] fuse_config_b;
reg [3:0] ctrl_r;
reg [15:0] vector_r;
reg [7:0] speed_setting_reg;
reg [7:0] interrupt_speed_reg;
reg [7:0] speed_shadow_r;
reg [3:0] flags_r;
reg [3:0] flags_nxt;
reg [3:0] ien_r;
reg [3:0] periph_en_r;
reg [7:0] timer0_count_reg;
reg [15:0] saved_pc_r;
reg [1:0] refill_r;
reg [1:0] refill_nxt;

wire chip_rst = !rst_n || rst_latch_r;
wire bod_act = bod_q && (fuse_config_b[2:0] != `RIRC_BOD_OFF);
wire src_any = !pin_high || bod_act || wdt_q || dbg_q;
wire [9:0] start_end = {fuse_config_a[2:0], `RIRC_STARTUP_LSB};
wire acc_wr = psel && penable && pready && pwrite;
wire t0_ovf = ctrl_r[`RIRC_CTRL_T0_RUN] && core_tick && (timer0_count_reg == 8'hff);
wire stop_sys = speed_setting_reg[7:4] == `RIRC_SPD_STOP;
wire stop_core = speed_setting_reg[3:0] == `RIRC_SPD_STOP;
wire [3:0] irq_act = flags_r & ien_r;
wire wake_req = |irq_act[`RIRC_SRC_RTC:`RIRC_SRC_PORT];
wire irq_go = ctrl_r[`RIRC_CTRL_GIE] && (|irq_act) && core_tick && !core_stall
    && !reti_vld && !rst_latch_r;
wire [3:0] hw_set;

// ------------------------------------------------------------
// Address decode
// ------------------------------------------------------------
function is_wr;
    input [7:0] a;
    input [7:0] off;
    begin
        is_wr = (a == off);
    end
endfunction

function is_mapped;
    input [7:0] a;
    begin
        is_mapped = (a[1:0] == 2'h0) && (a <= `RIRC_OFF_SPC_LO);
    end
endfunction

// ------------------------------------------------------------
// Pin synchroniser
// ------------------------------------------------------------
rirc_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({rtc_evt, port_evt, dbg_rst, wdt_ovf, bod_low, rst_pin_n}),
    .dout(pin_q)
);

// ------------------------------------------------------------
// Reset latch and startup timer
// ------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!rst_n) begin
        rst_latch_r <= 1'b1; // R14
        start_cnt_r <= 10'h000;
        wd_cause_r <= 1'b0;
        bo_cause_r <= 1'b0;
        fuse_config_a <= 8'h00;
        fuse_config_b <= 8'h00;
    end else begin
        if (rst_latch_r) begin
            fuse_config_a <= fuse_a_in; // R20
            fuse_config_b <= fuse_b_in; // R20
        end
        if (src_any) begin
            rst_latch_r <= 1'b1; // R26 R12 R18
            start_cnt_r <= 10'h000; // R26
            wd_cause_r <= wdt_q; // R16
            bo_cause_r <= bod_act; // R17
        end else if (rst_latch_r) begin
            if (start_cnt_r == start_end) begin // R15
                rst_latch_r <= 1'b0; // R14
            end else begin
                start_cnt_r <= start_cnt_r + 10'h001; // R14
            end
        end
    end
end

// ------------------------------------------------------------
// Interrupt flags
// ------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!rst_n) begin
        port_d_r <= 1'b0;
        rtc_d_r <= 1'b0;
    end else begin
        port_d_r <= port_q;
        rtc_d_r <= rtc_q;
    end
end

assign hw_set[`RIRC_SRC_PORT] = port_q && !port_d_r && periph_en_r[`RIRC_SRC_PORT]; // R6
assign hw_set[`RIRC_SRC_RTC] = rtc_q && !rtc_d_r && periph_en_r[`RIRC_SRC_RTC]; // R6
assign hw_set[`RIRC_SRC_T0] = t0_ovf && periph_en_r[`RIRC_SRC_T0]; // R6
assign hw_set[3] = 1'b0;

always @* begin
    flags_nxt = flags_r;
    if (acc_wr && is_wr(paddr, `RIRC_OFF_FLAGS)) begin
        flags_nxt = pwdata[3:0]; // R7
    end
    flags_nxt = flags_nxt | hw_set;
end

// ------------------------------------------------------------
// Refill counter
// ------------------------------------------------------------
always @* begin
    refill_nxt = refill_r;
    if (reti_vld && !rst_latch_r) begin
        refill_nxt = `RIRC_REFILL_CYC; // R5
    end else if (core_tick && (refill_r != 2'h0)) begin
        refill_nxt = refill_r - 2'h1; // R5
    end
end

// ------------------------------------------------------------
// Core-facing state
// ------------------------------------------------------------
always @(posedge clk_sys) begin
    if (chip_rst) begin
        ctrl_r <= `RIRC_CTRL_RST;
        vector_r <= `RIRC_VEC_RST; // R21
        speed_setting_reg <= `RIRC_SPD_RST; // R12
        interrupt_speed_reg <= `RIRC_SPD_RST;
        speed_shadow_r <= `RIRC_SPD_RST;
        flags_r <= 4'h0;
        ien_r <= 4'h0;
        periph_en_r <= 4'h0;
        timer0_count_reg <= 8'h00;
        saved_pc_r <= 16'h0000;
        refill_r <= 2'h0;
    end else begin
        flags_r <= flags_nxt; // R10
        refill_r <= refill_nxt;
        if (ctrl_r[`RIRC_CTRL_T0_RUN] && core_tick) begin
            timer0_count_reg <= timer0_count_reg + 8'h01;
        end
        if (acc_wr) begin
            if (is_wr(paddr, `RIRC_OFF_CTRL)) begin
                ctrl_r <= pwdata[3:0];
            end
            if (is_wr(paddr, `RIRC_OFF_VEC_HI)) begin
                vector_r[15:8] <= pwdata[7:0]; // R21
            end
            if (is_wr(paddr, `RIRC_OFF_VEC_LO)) begin
                vector_r[7:0] <= pwdata[7:0]; // R21
            end
            if (is_wr(paddr, `RIRC_OFF_SPEED)) begin
                speed_setting_reg <= pwdata[7:0]; // R9
            end
            if (is_wr(paddr, `RIRC_OFF_INT_SPEED)) begin
                interrupt_speed_reg <= pwdata[7:0];
            end
            if (is_wr(paddr, `RIRC_OFF_IEN)) begin
                ien_r <= pwdata[3:0];
            end
            if (is_wr(paddr, `RIRC_OFF_PERIPH_EN)) begin
                periph_en_r <= pwdata[3:0];
            end
            if (is_wr(paddr, `RIRC_OFF_TIMER0)) begin
                timer0_count_reg <= pwdata[7:0];
            end
        end
        if (irq_go) begin
            ctrl_r[`RIRC_CTRL_GIE] <= 1'b0;
            saved_pc_r <= core_pc;
            speed_shadow_r <= speed_setting_reg; // R25
            speed_setting_reg <= interrupt_speed_reg; // R25 R11
        end else if (reti_vld) begin
            ctrl_r[`RIRC_CTRL_GIE] <= 1'b1; // R23
            if (reti_opt[`RIRC_OPT_SPEED]) begin
                speed_setting_reg <= speed_shadow_r; // R1 R27
            end
            if (reti_opt[`RIRC_OPT_VEC]) begin
                vector_r <= reti_pc + 16'h0001; // R2 R4 R21 R27
            end
            if (reti_opt[`RIRC_OPT_T0ADD]) begin
                timer0_count_reg <= timer0_count_reg + w_acc; // R3 R27
            end
        end else if ((stop_sys || stop_core) && wake_req) begin
            speed_setting_reg <= `RIRC_SPD_RST; // R11
        end
    end
end

// ------------------------------------------------------------
// Core outputs
// ------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!rst_n) begin
        cpu_rst <= 1'b1;
        pc_load <= 1'b0;
        pc_val <= `RIRC_RESET_PC;
        irq_take <= 1'b0;
        core_stall <= 1'b0;
        core_clk_en <= 1'b1;
        sys_clk_en <= 1'b1;
        wdt_run <= 1'b0;
        rtc_run <= 1'b0;
        bod_en <= 1'b0;
        bod_level <= 3'h0;
    end else begin
        cpu_rst <= rst_latch_r;
        pc_load <= 1'b0;
        irq_take <= irq_go;
        core_stall <= (refill_nxt != 2'h0) && !rst_latch_r; // R5
        core_clk_en <= !(stop_sys || stop_core); // R9
        sys_clk_en <= !stop_sys; // R9
        wdt_run <= ctrl_r[`RIRC_CTRL_WDT_KEEP]; // R10
        rtc_run <= ctrl_r[`RIRC_CTRL_RTC_KEEP]; // R10
        bod_en <= fuse_config_b[2:0] != `RIRC_BOD_OFF; // R19
        bod_level <= fuse_config_b[2:0]; // R19
        if (rst_latch_r) begin
            pc_val <= `RIRC_RESET_PC; // R13
            pc_load <= !src_any && (start_cnt_r == start_end); // R13
        end else if (irq_go) begin
            pc_val <= vector_r; // R4
            pc_load <= 1'b1;
        end else if (reti_vld) begin
            pc_val <= saved_pc_r; // R24
            pc_load <= 1'b1;
        end
    end
end

// ------------------------------------------------------------
// APB slave, no wait states
// ------------------------------------------------------------
always @(posedge clk_sys) begin
    if (!rst_n) begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
    end else if (psel && !penable) begin
        pready <= 1'b1;
        pslverr <= !is_mapped(paddr);
        prdata <= 32'h00000000;
        if (!pwrite) begin
            case (paddr)
                `RIRC_OFF_CTRL: prdata[3:0] <= ctrl_r;
                `RIRC_OFF_VEC_HI: prdata[7:0] <= vector_r[15:8];
                `RIRC_OFF_VEC_LO: prdata[7:0] <= vector_r[7:0];
                `RIRC_OFF_SPEED: prdata[7:0] <= speed_setting_reg;
                `RIRC_OFF_INT_SPEED: prdata[7:0] <= interrupt_speed_reg;
                `RIRC_OFF_FLAGS: prdata[3:0] <= flags_r;
                `RIRC_OFF_IEN: prdata[3:0] <= ien_r;
                `RIRC_OFF_PERIPH_EN: prdata[3:0] <= periph_en_r;
                `RIRC_OFF_TIMER0: prdata[7:0] <= timer0_count_reg;
                `RIRC_OFF_STATUS: prdata[2:0] <= {rst_latch_r, bo_cause_r, wd_cause_r};
                `RIRC_OFF_FUSE_A: prdata[7:0] <= fuse_config_a; // R20
                `RIRC_OFF_FUSE_B: prdata[7:0] <= fuse_config_b; // R20
                `RIRC_OFF_SPC_HI: prdata[7:0] <= saved_pc_r[15:8];
                `RIRC_OFF_SPC_LO: prdata[7:0] <= saved_pc_r[7:0];
                default: prdata <= 32'h00000000;
            endcase
        end
    end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
    end
end

endmodule

// ---- rtl/rirc_defs.vh ----
// Constants for the reset and interrupt-return controller
`ifndef RIRC_DEFS_VH
`define RIRC_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define RIRC_OFF_CTRL 8'h00
`define RIRC_OFF_VEC_HI 8'h04
`define RIRC_OFF_VEC_LO 8'h08
`define RIRC_OFF_SPEED 8'h0c
`define RIRC_OFF_INT_SPEED 8'h10
`define RIRC_OFF_FLAGS 8'h14
`define RIRC_OFF_IEN 8'h18
`define RIRC_OFF_PERIPH_EN 8'h1c
`define RIRC_OFF_TIMER0 8'h20
`define RIRC_OFF_STATUS 8'h24
`define RIRC_OFF_FUSE_A 8'h28
`define RIRC_OFF_FUSE_B 8'h2c
`define RIRC_OFF_SPC_HI 8'h30
`define RIRC_OFF_SPC_LO 8'h34

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RIRC_CTRL_GIE 0
`define RIRC_CTRL_T0_RUN 1
`define RIRC_CTRL_WDT_KEEP 2
`define RIRC_CTRL_RTC_KEEP 3
`define RIRC_OPT_SPEED 2
`define RIRC_OPT_VEC 1
`define RIRC_OPT_T0ADD 0
`define RIRC_SRC_PORT 0
`define RIRC_SRC_RTC 1
`define RIRC_SRC_T0 2
`define RIRC_STAT_WD 0
`define RIRC_STAT_BO 1
`define RIRC_STAT_LATCH 2

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define RIRC_RESET_PC 16'hfff0
`define RIRC_VEC_RST 16'h0000
`define RIRC_SPD_RST 8'h93
`define RIRC_SPD_STOP 4'hf
`define RIRC_BOD_OFF 3'h7
`define RIRC_CTRL_RST 4'h0

// ------------------------------------------------------------
// Timing counts
// ------------------------------------------------------------
`define RIRC_REFILL_CYC 2'h2
`define RIRC_STARTUP_LSB 7'h7f

`endif

// ---- rtl/rirc_sync.v ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module rirc_sync (
    input wire clk_sys, // System clock
    input wire rst_n, // Synchronous reset, active low
    input wire [5:0] din, // Asynchronous pin levels
    output wire [5:0] dout // Filtered levels
);

reg [5:0] s1_r;
reg [5:0] s2_r;
reg [5:0] s3_r;
reg [5:0] q_r;

assign dout = q_r;

// ------------------------------------------------------------
// Per-bit stages
// ------------------------------------------------------------
genvar i;
generate
    for (i = 0; i < 6; i = i + 1) begin : g_bit
        always @(posedge clk_sys) begin
            if (!rst_n) begin
                s1_r[i] <= 1'b0;
                s2_r[i] <= 1'b0;
                s3_r[i] <= 1'b0;
                q_r[i] <= 1'b0;
            end else begin
                s1_r[i] <= din[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i]) begin
                    q_r[i] <= s3_r[i];
                end
            end
        end
    end
endgenerate

endmodule

// ---- test/rirc_ctrl_props.sv ----
// Checker for the reset and interrupt-return controller
`timescale 1ns/1ps
`include "rirc_defs.vh"
module rirc_ctrl_props (
    input wire clk_sys, // Clock
    input wire rst_n, // Reset
    input wire [7:0] paddr, // APB
    input wire psel, // APB
    input wire penable, // APB
    input wire pwrite, // APB
    input wire [31:0] pwdata, // APB
    input wire pready, // APB
    input wire pslverr, // APB
    input wire rst_pin_n, // Pin
    input wire bod_low, // Brown-out
    input wire wdt_ovf, // Watchdog
    input wire dbg_rst, // Debug
    input wire core_tick, // Tick
    input wire reti_vld, // Return
    input wire cpu_rst, // Core reset
    input wire pc_load, // PC load
    input wire [15:0] pc_val, // PC value
    input wire irq_take, // Entry
    input wire core_stall, // Refill
    input wire core_clk_en, // Gate
    input wire sys_clk_en, // Gate
    input wire wdt_run, // Keep
    input wire rtc_run, // Keep
    input wire bod_en, // Detector on
    input wire [2:0] bod_level // Level
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    reg [1:0] st_r;
    // Core ticks seen so far in one refill
    always @(posedge clk_sys) begin
        if (!rst_n || !core_stall)
            st_r <= 2'h0;
        else if (core_tick)
            st_r <= st_r + 2'h1;
    end
    sequence s_ctrl_wr;
        psel && penable && pready && pwrite && !pslverr && !cpu_rst && paddr == `RIRC_OFF_CTRL;
    endsequence
    sequence s_reti;
        reti_vld && !cpu_rst;
    endsequence
    sequence s_src_on;
        (!rst_pin_n || dbg_rst || wdt_ovf) [*8];
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    chk_reset_pc: assert property ($fell(cpu_rst) |-> $past(pc_load) && $past(pc_val) == `RIRC_RESET_PC)
        else $error("reset exit without pc load");
    chk_src_hold: assert property (s_src_on |-> cpu_rst)
        else $error("reset source did not hold core");
    chk_bod_hold: assert property ((bod_low && bod_en) [*8] |-> cpu_rst)
        else $error("low supply did not hold core");
    chk_bod_cfg: assert property (!cpu_rst |-> bod_en == (bod_level != `RIRC_BOD_OFF))
        else $error("detector enable disagrees with level");
    chk_irq_load: assert property (irq_take |-> pc_load && !cpu_rst)
        else $error("entry without vector load");
    chk_irq_pulse: assert property (irq_take |=> !irq_take [*2])
        else $error("entry repeated");
    chk_reti_load: assert property (s_reti |=> pc_load && core_stall && !irq_take)
        else $error("return without pc load and refill");
    chk_stall_len: assert property (core_stall |-> st_r < 2'h2)
        else $error("refill longer than two ticks");
    chk_clk_gate: assert property (!sys_clk_en |-> !core_clk_en)
        else $error("core clock runs with system clock stopped");
    chk_run_copy: assert property (s_ctrl_wr |-> ##2 wdt_run == $past(pwdata[2], 2) && rtc_run == $past(pwdata[3], 2))
        else $error("timer keep flags do not follow control");
endmodule
bind rirc_ctrl rirc_ctrl_props u_props (.*);

// ---- test/rirc_core_model.sv ----
// Behavioural core pipeline: clock-enable ticks and a halted PC
`timescale 1ns/1ps
module rirc_core_model (
    input wire clk_sys, // System clock
    input wire rst_n, // Reset, active low
    input wire cpu_rst, // Core held in reset
    input wire core_clk_en, // Core clock gate
    input wire pc_load, // Load PC pulse
    input wire [15:0] pc_val, // PC to load
    output wire core_tick, // Core clock enable
    output wire [15:0] core_pc // Current PC
);
    reg [15:0] pc_r;
    // Core never fetches, so the PC moves only on loads
    assign core_tick = core_clk_en & ~cpu_rst;
    assign core_pc = pc_r;
    always @(posedge clk_sys) begin
        if (!rst_n)
            pc_r <= 16'hfff0;
        else if (pc_load)
            pc_r <= pc_val;
    end
endmodule

// ---- test/tb_top.sv ----
// Testbench for the reset and interrupt-return controller
`timescale 1ns/1ps
`include "rirc_defs.vh"
module tb_top;
    reg clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg rst_pin_n = 1'b1, bod_low = 1'b0, wdt_ovf = 1'b0, dbg_rst = 1'b0;
    reg port_evt = 1'b0, rtc_evt = 1'b0, reti_vld = 1'b0, re = 1'b0;
    reg [7:0] paddr = 8'h00, fuse_a_in = 8'h00, fuse_b_in = 8'h00, w_acc = 8'h00;
    reg [31:0] pwdata = 32'h0, rq = 32'h0;
    reg [2:0] reti_opt = 3'h0;
    reg [15:0] reti_pc = 16'h0;
    wire [31:0] prdata;
    wire pready, pslverr, core_tick, cpu_rst, pc_load, irq_take, core_stall;
    wire core_clk_en, sys_clk_en, wdt_run, rtc_run, bod_en;
    wire [15:0] core_pc, pc_val;
    wire [2:0] bod_level;
    int err_count = 0, n_checks = 0, n;
    rirc_ctrl dut (.*);
    rirc_core_model u_core (.*);
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", nm, exp, got);
            err_count++;
        end
    endtask
    task tmo(input string nm);
        $display("FAIL timeout %s expected 1 seen 0", nm);
        err_count++;
        print_verdict;
    endtask
    task cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            if (++k > 20)
                tmo("apb");
        end while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rq, exp);
    endtask
    task wait_boot(output int c);
        c = 0;
        @(negedge clk_sys);
        while (pc_load !== 1'b1) begin
            if (++c > 3000)
                tmo("boot");
            @(negedge clk_sys);
        end
        chk("boot pc", 32'(pc_val), 32'(`RIRC_RESET_PC));
        @(negedge clk_sys);
    endtask
    task por(input logic [7:0] fa, input logic [7:0] fb);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        fuse_a_in <= fa;
        fuse_b_in <= fb;
        cyc(2);
        rst_n <= 1'b1;
        wait_boot(n);
    endtask
    // Source 0 port, 1 watchdog, 2 debug, 3 supply low, other pin low
    task pulse(input int s, input int len);
        @(posedge clk_sys);
        case (s)
            0: port_evt <= 1'b1;
            1: wdt_ovf <= 1'b1;
            2: dbg_rst <= 1'b1;
            3: bod_low <= 1'b1;
            default: rst_pin_n <= 1'b0;
        endcase
        cyc(len);
        port_evt <= 1'b0;
        wdt_ovf <= 1'b0;
        dbg_rst <= 1'b0;
        bod_low <= 1'b0;
        rst_pin_n <= 1'b1;
    endtask
    task wait_irq(input logic [15:0] exp);
        int k;
        k = 0;
        @(negedge clk_sys);
        while (irq_take !== 1'b1) begin
            if (++k > 100)
                tmo("irq");
            @(negedge clk_sys);
        end
        chk("vector", 32'({pc_load, pc_val}), {15'h0, 1'b1, exp});
    endtask
    task reti(input logic [2:0] o, input logic [15:0] p, input logic [7:0] a);
        int k;
        @(posedge clk_sys);
        reti_vld <= 1'b1;
        reti_opt <= o;
        reti_pc <= p;
        w_acc <= a;
        @(posedge clk_sys);
        reti_vld <= 1'b0;
        @(negedge clk_sys);
        chk("reti pc", 32'({pc_load, pc_val}), 32'h1fff0);
        k = 0;
        while (core_stall === 1'b1 && k < 9) begin
            k++;
            @(negedge clk_sys);
        end
        chk("refill", k, 32'h2);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_boot;
        por(8'h00, 8'h02);
        chk("boot len", 32'(n >= 128 && n <= 140), 32'h1);
        rdc("status", `RIRC_OFF_STATUS, 32'h0);
        wr(`RIRC_OFF_FUSE_B, 32'hff);
        rdc("fuse b", `RIRC_OFF_FUSE_B, 32'h2);
        chk("bod cfg", 32'({bod_en, bod_level}), 32'ha);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'(re), 32'h1);
        chk("unmapped data", rq, 32'h0);
        $display("test boot done");
    endtask
    task t_irq;
        wr(`RIRC_OFF_SPEED, 32'h11);
        wr(`RIRC_OFF_VEC_HI, 32'h12);
        wr(`RIRC_OFF_VEC_LO, 32'h34);
        wr(`RIRC_OFF_TIMER0, 32'h10);
        wr(`RIRC_OFF_IEN, 32'h8);
        wr(`RIRC_OFF_CTRL, 32'h1);
        rdc("int speed", `RIRC_OFF_INT_SPEED, 32'h93);
        wr(`RIRC_OFF_FLAGS, 32'h8);
        wait_irq(16'h1234);
        rdc("isr speed", `RIRC_OFF_SPEED, 32'h93);
        rdc("saved pc", `RIRC_OFF_SPC_LO, 32'hf0);
        wr(`RIRC_OFF_FLAGS, 32'h0);
        reti(3'h7, 16'h2000, 8'h05);
        rdc("vec hi", `RIRC_OFF_VEC_HI, 32'h20);
        rdc("vec lo", `RIRC_OFF_VEC_LO, 32'h01);
        rdc("timer0", `RIRC_OFF_TIMER0, 32'h15);
        rdc("speed", `RIRC_OFF_SPEED, 32'h11);
        rdc("ctrl", `RIRC_OFF_CTRL, 32'h1);
        wr(`RIRC_OFF_FLAGS, 32'h8);
        wait_irq(16'h2001);
        wr(`RIRC_OFF_FLAGS, 32'h0);
        reti(3'h0, 16'h3000, 8'h07);
        rdc("vec kept", `RIRC_OFF_VEC_LO, 32'h01);
        rdc("timer kept", `RIRC_OFF_TIMER0, 32'h15);
        rdc("isr speed kept", `RIRC_OFF_SPEED, 32'h93);
        wr(`RIRC_OFF_CTRL, 32'h0);
        $display("test return done");
    endtask
    task t_periph;
        wr(`RIRC_OFF_PERIPH_EN, 32'h0);
        pulse(0, 4);
        cyc(8);
        rdc("flag off", `RIRC_OFF_FLAGS, 32'h0);
        wr(`RIRC_OFF_PERIPH_EN, 32'h1);
        pulse(0, 4);
        cyc(8);
        rdc("flag on", `RIRC_OFF_FLAGS, 32'h1);
        wr(`RIRC_OFF_FLAGS, 32'h0);
        $display("test disabled done");
    endtask
    task t_stop;
        wr(`RIRC_OFF_CTRL, 32'hc);
        cyc(3);
        chk("keep timers", 32'({wdt_run, rtc_run}), 32'h3);
        wr(`RIRC_OFF_IEN, 32'h1);
        wr(`RIRC_OFF_SPEED, 32'h3f);
        cyc(2);
        chk("core stop", 32'({sys_clk_en, core_clk_en}), 32'h2);
        wr(`RIRC_OFF_SPEED, 32'hf3);
        cyc(2);
        chk("sys stop", 32'({sys_clk_en, core_clk_en}), 32'h0);
        pulse(0, 4);
        n = 0;
        while (sys_clk_en !== 1'b1) begin
            if (++n > 100)
                tmo("wake");
            @(negedge clk_sys);
        end
        chk("wake no reset", 32'(cpu_rst), 32'h0);
        wr(`RIRC_OFF_FLAGS, 32'h0);
        wr(`RIRC_OFF_SPEED, 32'hf3);
        pulse(1, 6);
        wait_boot(n);
        rdc("wd cause", `RIRC_OFF_STATUS, 32'h1);
        $display("test stop done");
    endtask
    task t_bod;
        pulse(3, 40);
        @(negedge clk_sys);
        chk("bod hold", 32'(cpu_rst), 32'h1);
        wait_boot(n);
        rdc("bo cause", `RIRC_OFF_STATUS, 32'h2);
        fuse_a_in <= 8'h01;
        pulse(4, 10);
        wait_boot(n);
        chk("pin len", 32'(n >= 256 && n <= 268), 32'h1);
        rdc("pin cause", `RIRC_OFF_STATUS, 32'h0);
        pulse(2, 6);
        wait_boot(n);
        por(8'h00, 8'h07);
        chk("bod off", 32'({bod_en, bod_level}), 32'h7);
        pulse(3, 20);
        @(negedge clk_sys);
        cyc(8);
        chk("bod ignored", 32'(cpu_rst), 32'h0);
        $display("test supply done");
    endtask
    initial begin
        t_boot;
        t_irq;
        t_periph;
        t_stop;
        t_bod;
        print_verdict;
    end
endmodule
